// file: lcce_top.sv
// Notes on behaviour
// [RULE1] Only a block whose opcode is the configure code loads parameters.
// [RULE2] At most twenty-two configuration bytes taken; extra ones ignored.
// [RULE3] Fewer than eight bytes is an error; host must supply eight.
// [RULE4] Bytes 0-7 stay here; the rest go out the transmit stream.
// [RULE5] Unsupplied parameters revert to defaults, except the PHY bit.
// [RULE6] Later generations: no traffic until PHY bit configured as one.
// [RULE7] First generation: no traffic until PHY bit configured at all.
// [RULE8] Host keeps byte 3 all zero on the first generation.
// [RULE9] Byte 4 holds a seven-bit count; its top bit is zero.
// [RULE10] Byte count field of byte 0 sets how many bytes are fetched.
// [RULE11] On finish set completion bit 15, bit 13 only without error.
// [RULE12] End-of-list flag: unit goes idle, not-active interrupt always.
// [RULE13] Suspend flag: unit suspends, not-active interrupt if enabled.
// [RULE14] Interrupt flag alone raises the command-executed interrupt.
`timescale 1ns/1ps
`include "lcce_cfg.svh"

module lcce_top
    import lcce_pkg::*;
#(
    parameter bit FIRST_GEN = 1'b0
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [31:0] cbAddr,
    output lcce_mem_s        memOut,
    input  wire logic        memAck,
    input  wire logic [31:0] memRData,
    output lcce_tx_s         txOut,
    input  wire logic        txReady,
    output lcce_cfg_t        cfg,
    output logic             cuIdle,
    output logic             cuSuspended,
    output logic             cmdDone,
    output logic             unitNotActiveIntr,
    output logic             cmdExecutedIntr,
    output logic             macEnable
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rstPipe_ff;
    wire logic  rstSync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstSync = rstPipe_ff[1];

    // ------------------------------------------------------------------
    // State and datapath registers
    // ------------------------------------------------------------------
    lcce_state_e state_ff;
    lcce_cmd_s   cmd_ff;
    lcce_mem_s   mem_ff;
    lcce_tx_s    tx_ff;
    logic [31:0] base_ff;
    logic [31:0] word_ff;
    logic [4:0]  idx_ff;
    logic [4:0]  cnt_ff;
    logic        ok_ff;
    logic        idle_ff;
    logic        susp_ff;
    logic        done_ff;
    logic        cna_ff;
    logic        cx_ff;
    logic        phySeen_ff;
    logic        phyVal_ff;
    logic        mac_ff;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic       inByte   = (state_ff == ST_BYTE);
    wire logic       inMem    = (state_ff == ST_HDR) || (state_ff == ST_WORD)
                                || (state_ff == ST_STAT);
    wire logic       memDone  = mem_ff.req && memAck;
    wire logic       isCfgOp  = (memRData[18:16] == `LCCE_OP_CONFIGURE);
    wire logic [7:0] curByte  = word_ff[{idx_ff[1:0], 3'h0} +: 8];
    wire logic [5:0] rawCnt   = curByte[5:0]; // [RULE10]
    wire logic       firstB   = (idx_ff == 5'h00);
    wire logic       shortCnt = firstB &&
                                (rawCnt < {1'b0, `LCCE_MIN_BYTES}); // [RULE3]
    wire logic [4:0] clampCnt = (rawCnt > {1'b0, `LCCE_MAX_BYTES}) ?
                                `LCCE_MAX_BYTES : rawCnt[4:0]; // [RULE2]
    wire logic [4:0] effCnt   = firstB ? clampCnt : cnt_ff;
    wire logic [4:0] idxInc   = idx_ff + 5'h01;
    wire logic       lastByte = (idxInc == effCnt);
    wire logic       cuByte   = (idx_ff < `LCCE_CU_BYTES);
    wire logic       storeWr  = inByte && !shortCnt && cuByte; // [RULE4]
    wire logic       txLoad   = inByte && !shortCnt && !cuByte; // [RULE4]
    wire logic       advance  = storeWr || ((state_ff == ST_SEND) && txReady);
    wire logic       loadDef  = (state_ff == ST_HDR) && memDone
                                && isCfgOp; // [RULE1]
    wire logic       ciEnable = cfg[`LCCE_CI_BYTE][`LCCE_CI_BIT];
    wire logic       finish   = (state_ff == ST_STAT) && memDone;
    wire logic [31:0] wordAddr = base_ff + `LCCE_OFS_CFG
                                 + {27'h0, idx_ff[4:2], 2'h0};
    wire logic [31:0] statWord = {cmd_ff, 1'b1, 1'b0, ok_ff, 13'h0}; // [RULE11]
    wire logic        phyNow  = txLoad && (idx_ff == `LCCE_PHY_BYTE);
    wire logic        nxtMac  = FIRST_GEN ? phySeen_ff
                                : (phySeen_ff && phyVal_ff); // [RULE6] [RULE7]

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            state_ff <= ST_IDLE;
            cmd_ff   <= '0;
            base_ff  <= 32'h0;
            word_ff  <= 32'h0;
            idx_ff   <= 5'h00;
            cnt_ff   <= 5'h00;
            ok_ff    <= 1'b1;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        base_ff  <= cbAddr;
                        idx_ff   <= 5'h00;
                        ok_ff    <= 1'b1;
                        state_ff <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    if (memDone) begin
                        cmd_ff   <= memRData[31:16];
                        ok_ff    <= isCfgOp; // [RULE1]
                        state_ff <= isCfgOp ? ST_WORD : ST_STAT;
                    end
                end
                ST_WORD: begin
                    if (memDone) begin
                        word_ff  <= memRData;
                        state_ff <= ST_BYTE;
                    end
                end
                ST_BYTE: begin
                    if (firstB) begin
                        cnt_ff <= clampCnt; // [RULE10]
                    end
                    if (shortCnt) begin
                        ok_ff    <= 1'b0; // [RULE3]
                        state_ff <= ST_STAT;
                    end else if (txLoad) begin
                        state_ff <= ST_SEND;
                    end
                end
                ST_SEND: begin
                end
                ST_STAT: begin
                    if (memDone) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
            if (advance) begin
                idx_ff   <= idxInc;
                state_ff <= lastByte ? ST_STAT
                          : (idx_ff[1:0] == 2'h3) ? ST_WORD : ST_BYTE; // [RULE2]
            end
        end
    end

    // ------------------------------------------------------------------
    // Memory requests and transmit stream
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            mem_ff <= '0;
            tx_ff  <= '0;
        end else begin
            if (memDone) begin
                mem_ff.req <= 1'b0;
            end else if (inMem && !mem_ff.req) begin
                mem_ff.req   <= 1'b1;
                mem_ff.we    <= (state_ff == ST_STAT);
                mem_ff.addr  <= (state_ff == ST_WORD) ? wordAddr : base_ff;
                mem_ff.wdata <= statWord;
            end
            if (txLoad) begin
                tx_ff <= '{valid: 1'b1, last: lastByte, data: curByte};
            end else if (txReady) begin
                tx_ff.valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Completion, unit state, interrupts, PHY gate
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            idle_ff    <= 1'b1;
            susp_ff    <= 1'b0;
            done_ff    <= 1'b0;
            cna_ff     <= 1'b0;
            cx_ff      <= 1'b0;
            phySeen_ff <= 1'b0;
            phyVal_ff  <= 1'b0;
            mac_ff     <= 1'b0;
        end else begin
            done_ff <= finish;
            cx_ff   <= finish && cmd_ff.intr; // [RULE14]
            cna_ff  <= finish && (cmd_ff.el
                       || (cmd_ff.susp && ciEnable)); // [RULE12] [RULE13]
            if (start && (state_ff == ST_IDLE)) begin
                idle_ff <= 1'b0;
                susp_ff <= 1'b0;
            end else if (finish) begin
                idle_ff <= cmd_ff.el; // [RULE12]
                susp_ff <= !cmd_ff.el && cmd_ff.susp; // [RULE13]
            end
            if (phyNow) begin
                phySeen_ff <= 1'b1;
                phyVal_ff  <= curByte[0];
            end
            mac_ff <= nxtMac;
        end
    end

    lcce_cfg_store u_store (
        .clk      (clk),
        .rstSyncN (rstSync),
        .loadDef  (loadDef),
        .wrEn     (storeWr),
        .wrIdx    (idx_ff[2:0]),
        .wrData   (curByte),
        .cfg      (cfg)
    );

    assign memOut            = mem_ff;
    assign txOut             = tx_ff;
    assign cuIdle            = idle_ff;
    assign cuSuspended       = susp_ff;
    assign cmdDone           = done_ff;
    assign unitNotActiveIntr = cna_ff;
    assign cmdExecutedIntr   = cx_ff;
    assign macEnable         = mac_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rstSync);

    sequence s_tx_stall;
        tx_ff.valid && !txReady;
    endsequence
    sequence s_short_seen;
        inByte && shortCnt;
    endsequence

    a_opcode_gate: assert property ( // [RULE1]
        (state_ff == ST_HDR) && memDone && !isCfgOp
        |=> (state_ff == ST_STAT) && !ok_ff)
        else $error("non-configure block not rejected");
    a_byte_limit: assert property ( // [RULE2]
        txLoad |-> (idx_ff < `LCCE_MAX_BYTES))
        else $error("byte beyond limit forwarded");
    a_short_error: assert property ( // [RULE3]
        s_short_seen |=> (state_ff == ST_STAT) && !ok_ff ##1 mem_ff.req)
        else $error("short list not flagged");
    a_cu_split: assert property ( // [RULE4]
        storeWr |-> !txLoad && (idx_ff < 5'h08))
        else $error("byte routed wrong way");
    a_tx_hold: assert property ( // [RULE4]
        s_tx_stall |=> tx_ff.valid && $stable(tx_ff.data))
        else $error("stream byte dropped under stall");
    a_phy_gate: assert property ( // [RULE7]
        mac_ff |-> phySeen_ff && (FIRST_GEN || phyVal_ff))
        else $error("traffic enabled before PHY bit");
    a_count_taken: assert property ( // [RULE10]
        inByte && firstB && !shortCnt |=> cnt_ff == $past(clampCnt))
        else $error("byte count not taken");
    a_status_bits: assert property ( // [RULE11]
        mem_ff.req && mem_ff.we |-> mem_ff.wdata[`LCCE_BIT_C]
        && (mem_ff.wdata[`LCCE_BIT_OK] == ok_ff))
        else $error("status word wrong");
    a_el_idle: assert property ( // [RULE12]
        finish && cmd_ff.el |=> idle_ff && cna_ff && done_ff)
        else $error("end of list not honoured");
    a_susp_state: assert property ( // [RULE13]
        finish && cmd_ff.susp && !cmd_ff.el
        |=> susp_ff && (cna_ff == $past(ciEnable)))
        else $error("suspend not honoured");
    a_cx_only: assert property ( // [RULE14]
        cx_ff == (done_ff && $past(cmd_ff.intr)))
        else $error("command interrupt wrong");

endmodule : lcce_top

// file: lcce_cfg.svh
`ifndef LCCE_CFG_SVH
`define LCCE_CFG_SVH

// ----------------------------------------------------------------------
// Command block layout
// ----------------------------------------------------------------------
`define LCCE_OP_CONFIGURE   3'h2
`define LCCE_OFS_CFG        32'h0000_0008
`define LCCE_BIT_EL         31
`define LCCE_BIT_SUSP       30
`define LCCE_BIT_INTR       29
`define LCCE_BIT_C          15
`define LCCE_BIT_OK         13

// ----------------------------------------------------------------------
// Configuration byte limits and fields
// ----------------------------------------------------------------------
`define LCCE_MAX_BYTES      5'h16
`define LCCE_MIN_BYTES      5'h08
`define LCCE_CU_BYTES       5'h08
`define LCCE_PHY_BYTE       5'h08
`define LCCE_CI_BYTE        3'h6
`define LCCE_CI_BIT         3
`define LCCE_RXMAX_BYTE     3'h4
`define LCCE_RXMAX_MASK     8'h7f
`define LCCE_DEF_CFG        64'h0300_3200_0000_0816

`endif

// file: lcce_pkg.sv
package lcce_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_HDR  = 6'h02,
        ST_WORD = 6'h04,
        ST_BYTE = 6'h08,
        ST_SEND = 6'h10,
        ST_STAT = 6'h20
    } lcce_state_e;

    typedef struct packed {
        logic       el;
        logic       susp;
        logic       intr;
        logic [9:0] rsvd;
        logic [2:0] opcode;
    } lcce_cmd_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } lcce_mem_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } lcce_tx_s;

    typedef logic [7:0][7:0] lcce_cfg_t;

endpackage : lcce_pkg

// file: lcce_cfg_store.sv
`timescale 1ns/1ps
`include "lcce_cfg.svh"

module lcce_cfg_store
    import lcce_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstSyncN,
    input  wire logic       loadDef,
    input  wire logic       wrEn,
    input  wire logic [2:0] wrIdx,
    input  wire logic [7:0] wrData,
    output lcce_cfg_t       cfg
);

    lcce_cfg_t cfg_ff;
    lcce_cfg_t nxt_cfg;
    wire logic [7:0] maskedData;

    // Top bit of the receive DMA count byte never stored
    assign maskedData = (wrIdx == `LCCE_RXMAX_BYTE) ?
                        (wrData & `LCCE_RXMAX_MASK) : wrData; // [RULE9]

    always_comb begin
        nxt_cfg = loadDef ? lcce_cfg_t'(`LCCE_DEF_CFG) : cfg_ff; // [RULE5]
        if (wrEn) begin
            nxt_cfg[wrIdx] = maskedData;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cfg_ff <= lcce_cfg_t'(`LCCE_DEF_CFG);
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign cfg = cfg_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rxmax_top_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
        !cfg_ff[`LCCE_RXMAX_BYTE][7]) // [RULE9]
        else $error("receive DMA count top bit set");

    a_default_reload: assert property (@(posedge clk) disable iff (!rstSyncN)
        loadDef && !wrEn |=> cfg_ff == lcce_cfg_t'(`LCCE_DEF_CFG)) // [RULE5]
        else $error("defaults not reloaded");

endmodule : lcce_cfg_store

// file: lcce_host_mem.sv
`timescale 1ns/1ps

module lcce_host_mem
    import lcce_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire lcce_mem_s   memOut,
    output logic             memAck,
    output logic [31:0]      memRData
);
    logic [31:0] mem [16];
    logic [1:0]  waitCnt;
    wire  [3:0]  wIdx    = memOut.addr[5:2];
    wire  [1:0]  waitLen = slow ? 2'h3 : 2'h0;

    initial begin
        memAck   = 1'b0;
        memRData = 32'h0;
        waitCnt  = 2'h0;
    end

    // Data line toggles unless a read word is being answered
    always @(posedge clk) begin
        memAck   <= 1'b0;
        memRData <= ~memRData;
        if (memOut.req && !memAck) begin
            if (waitCnt == waitLen) begin
                memAck  <= 1'b1;
                waitCnt <= 2'h0;
                if (memOut.we)
                    mem[wIdx] <= memOut.wdata;
                else
                    memRData <= mem[wIdx];
            end else begin
                waitCnt <= waitCnt + 2'h1;
            end
        end
    end
endmodule : lcce_host_mem

// file: lan_configure_command_exec_test.sv
`timescale 1ns/1ps

module lan_configure_command_exec_test
    import lcce_pkg::*;
;
    logic        clk, rstn, start, memAck, txReady, slow, stall;
    logic [31:0] cbAddr, memRData;
    lcce_mem_s   memOut;
    lcce_tx_s    txOut;
    lcce_cfg_t   cfg, cfgOld;
    logic        cuIdle, cuSuspended, cmdDone, naIntr, cxIntr, macEnable;
    logic        gotNa, gotCx, macG1;
    logic [7:0]  expB [32];
    logic [8:0]  txQ [$];
    int          error_cnt, n_checks;

    lcce_top lcce_top_inst (
        .clk(clk), .rstn(rstn), .start(start), .cbAddr(cbAddr),
        .memOut(memOut), .memAck(memAck), .memRData(memRData),
        .txOut(txOut), .txReady(txReady), .cfg(cfg), .cuIdle(cuIdle),
        .cuSuspended(cuSuspended), .cmdDone(cmdDone),
        .unitNotActiveIntr(naIntr), .cmdExecutedIntr(cxIntr),
        .macEnable(macEnable));

    // First-generation twin runs in lockstep on the same inputs
    lcce_top #(.FIRST_GEN(1'b1)) lcce_top_gen1_inst (
        .clk(clk), .rstn(rstn), .start(start), .cbAddr(cbAddr),
        .memOut(), .memAck(memAck), .memRData(memRData),
        .txOut(), .txReady(txReady), .cfg(), .cuIdle(),
        .cuSuspended(), .cmdDone(), .unitNotActiveIntr(),
        .cmdExecutedIntr(), .macEnable(macG1));

    lcce_host_mem lcce_host_mem_inst (
        .clk(clk), .slow(slow), .memOut(memOut), .memAck(memAck),
        .memRData(memRData));

    // ------------------------------------------------------------------
    // Clock and transmit sink
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        txReady <= stall ? ~txReady : 1'b1;
        if (txOut.valid === 1'b1 && txReady)
            txQ.push_back({txOut.last, txOut.data});
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task finish_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic run_cmd(input logic [15:0] hdr,
                           input logic [7:0] cnt, b6, b8,
                           input int nFwd, input logic ok);
        int k;
        for (k = 0; k < 32; k++) expB[k] = 8'h30 + 8'(k);
        expB[0] = cnt;
        expB[3] = 8'h00;
        expB[4] = 8'h44;
        expB[6] = b6;
        expB[8] = b8;
        lcce_host_mem_inst.mem[0] = {hdr, 16'h0000};
        for (k = 0; k < 8; k++)
            lcce_host_mem_inst.mem[2 + k] = {expB[4 * k + 3],
                expB[4 * k + 2], expB[4 * k + 1], expB[4 * k]};
        txQ.delete();
        cfgOld = cfg;
        @(posedge clk);
        start  <= 1'b1;
        cbAddr <= 32'h0000_0100;
        @(posedge clk);
        start  <= 1'b0;
        for (k = 0; k < 600 && cmdDone !== 1'b1; k++) @(negedge clk);
        if (k == 600) begin
            error_cnt++;
            finish_test();
        end
        gotNa = naIntr;
        gotCx = cxIntr;
        chk("status", lcce_host_mem_inst.mem[0],
            {hdr, 1'b1, 1'b0, ok, 13'h0});
        chk("fwdCount", 32'(txQ.size()), 32'(nFwd));
        for (k = 0; k < txQ.size(); k++)
            chk("fwdByte", 32'(txQ[k]),
                {23'h0, k == nFwd - 1, expB[8 + k]});
        chk("cxIntr", 32'(gotCx), 32'(hdr[13]));
    endtask : run_cmd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        chk("idleRst", 32'(cuIdle), 32'h1);
        chk("macRst", 32'(macEnable), 32'h0);
        chk("macG1Rst", 32'(macG1), 32'h0);
        chk("cfgDefLo", cfg[3:0], 32'h0000_0816);
        chk("cfgDefHi", cfg[7:4], 32'h0300_3200);
    endtask : t_reset

    task t_phy_zero;
        run_cmd(16'h0002, 8'h09, 8'h00, 8'h00, 1, 1'b1);
        chk("macPhy0", 32'(macEnable), 32'h0);
        chk("macG1Phy0", 32'(macG1), 32'h1);
        chk("naPlain", 32'(gotNa), 32'h0);
    endtask : t_phy_zero

    task t_full;
        slow  <= 1'b1;
        stall <= 1'b1;
        run_cmd(16'ha002, 8'h16, 8'h00, 8'h01, 14, 1'b1);
        for (int k = 0; k < 8; k++)
            chk("cfgByte", 32'(cfg[k]), 32'(expB[k]));
        chk("naEl", 32'(gotNa), 32'h1);
        chk("idleEl", 32'(cuIdle), 32'h1);
        chk("macPhy1", 32'(macEnable), 32'h1);
        slow  <= 1'b0;
        stall <= 1'b0;
    endtask : t_full

    task t_clamp;
        run_cmd(16'h2002, 8'h19, 8'h00, 8'h01, 14, 1'b1);
    endtask : t_clamp

    task t_short;
        run_cmd(16'h0002, 8'h05, 8'h00, 8'h01, 0, 1'b0);
        chk("cfgShortLo", cfg[3:0], 32'h0000_0816);
        chk("cfgShortHi", cfg[7:4], 32'h0300_3200);
    endtask : t_short

    task t_other_op;
        run_cmd(16'h0000, 8'h16, 8'h08, 8'h01, 0, 1'b0);
        chk("cfgKeptLo", cfg[3:0], cfgOld[3:0]);
        chk("cfgKeptHi", cfg[7:4], cfgOld[7:4]);
    endtask : t_other_op

    task t_suspend;
        run_cmd(16'h4002, 8'h08, 8'h08, 8'h01, 0, 1'b1);
        chk("naSuspOn", 32'(gotNa), 32'h1);
        chk("suspended", 32'(cuSuspended), 32'h1);
        chk("notIdle", 32'(cuIdle), 32'h0);
        run_cmd(16'h6002, 8'h08, 8'h00, 8'h01, 0, 1'b1);
        chk("naSuspOff", 32'(gotNa), 32'h0);
    endtask : t_suspend

    initial begin
        rstn    = 1'b0;
        start   = 1'b0;
        cbAddr  = 32'h0;
        slow    = 1'b0;
        stall   = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        t_reset();
        t_phy_zero();
        t_full();
        t_clamp();
        t_short();
        t_other_op();
        t_suspend();
        finish_test();
    end
endmodule : lan_configure_command_exec_test
